// *** hdl/pmg_guard.v ***
`include "pmg_map.vh"
`default_nettype none

module pmg_guard #(
  parameter PM_WORDS = 4096
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  input  wire        fetch_valid,
  input  wire [14:0] fetch_addr,
  output reg         exec_viol_reset_q,
  input  wire        ind_rd_req,
  input  wire        ind_wr_req,
  input  wire [15:0] ind_ptr,
  input  wire [7:0]  ind_wdata,
  input  wire [7:0]  dm_rdata,
  input  wire [13:0] pm_rdata,
  output reg  [15:0] pm_raddr_q,
  output reg  [7:0]  ind_rdata_q,
  output reg         ind_done_q,
  output reg         ind_busy_q,
  output reg         dm_we_q,
  output reg  [15:0] dm_waddr_q,
  output reg  [7:0]  dm_wdata_q,
  input  wire        nvm_wr_req,
  input  wire [15:0] nvm_wr_addr,
  output reg         nvm_wr_en_q,
  output reg  [15:0] nvm_wr_addr_q,
  output reg         nvm_wr_err_q
);

  localparam integer LAST_INT  = PM_WORDS - 1;
  localparam [15:0]  LAST_ADDR = LAST_INT[15:0];
  localparam [0:0]  ST_IDLE   = 1'b0;
  localparam [0:0]  ST_PM     = 1'b1;

  // ************************************************************
  // helpers
  // ************************************************************
  // wrap a user-flash address, leave the high space untouched
  function [15:0] wrap_addr;
    input [15:0] a;
    begin
      if (a[`PMG_PM_SPACE_BIT])
        wrap_addr = a;
      else
        wrap_addr = a & LAST_ADDR;
    end
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  reg  [31:0] cfg_q;
  reg         write_error_flag_q;
  reg         viol_flag_q;
  reg  [0:0]  ist_q;
  wire [2:0]  fetch_rgn;
  wire [2:0]  wr_rgn;
  wire        boot_en_n = cfg_q[`PMG_CFG_BOOT_EN_N];
  wire        saf_en_n  = cfg_q[`PMG_CFG_SAF_EN_N];
  wire [2:0]  bsize     = cfg_q[`PMG_CFG_BSIZE_MSB:`PMG_CFG_BSIZE_LSB];
  wire        apb_setup = psel & ~penable;
  wire        apb_wr    = psel & penable & pready_q & pwrite;
  reg         wr_prot;
  reg         bad_fetch;
  reg  [31:0] rd_mux;
  reg         addr_ok;

  // ************************************************************
  // partition decoders for fetch and write paths
  // ************************************************************
  pmg_part_decode #(
    .PM_WORDS  (PM_WORDS)
  ) u_fetch_dec (
    .addr      ({1'b0, fetch_addr}),
    .boot_en_n (boot_en_n),
    .saf_en_n  (saf_en_n),
    .bsize_sel (bsize),
    .region    (fetch_rgn)
  );

  pmg_part_decode #(
    .PM_WORDS  (PM_WORDS)
  ) u_wr_dec (
    .addr      (nvm_wr_addr),
    .boot_en_n (boot_en_n),
    .saf_en_n  (saf_en_n),
    .bsize_sel (bsize),
    .region    (wr_rgn)
  );

  // ************************************************************
  // protection and execution checks
  // ************************************************************
  // write protect per partition, info areas never writable
  always @* begin
    case (wr_rgn)
      `PMG_RGN_APP:  wr_prot = cfg_q[`PMG_CFG_WP_APP];
      `PMG_RGN_BOOT: wr_prot = cfg_q[`PMG_CFG_WP_BOOT];
      `PMG_RGN_CFG:  wr_prot = cfg_q[`PMG_CFG_WP_CFG];
      `PMG_RGN_SAF:  wr_prot = cfg_q[`PMG_CFG_WP_SAF];
      `PMG_RGN_DIA:  wr_prot = 1'b1;
      default:       wr_prot = 1'b1;
    endcase
    bad_fetch = fetch_valid && (fetch_rgn == `PMG_RGN_SAF);
  end

  // ************************************************************
  // apb register file
  // ************************************************************
  // read mux and address check
  always @* begin
    rd_mux  = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      `PMG_OFS_CFG:      rd_mux = cfg_q;
      `PMG_OFS_NVM_STAT: rd_mux[`PMG_NVM_WRITE_ERROR_FLAG_BIT] = write_error_flag_q;
      `PMG_OFS_PWR_STAT: rd_mux[`PMG_PWR_VIOL_BIT] = viol_flag_q;
      `PMG_OFS_INFO:     rd_mux[15:0] = LAST_ADDR;
      default:           addr_ok = 1'b0;
    endcase
  end

  // software write completing at this edge to the given offset
  function wr_hit;
    input [11:0] ofs;
    begin
      wr_hit = apb_wr && (paddr == ofs);
    end
  endfunction

  // ************************************************************
  // apb handshake
  // ************************************************************
  // zero-wait answer: ready in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & ~addr_ok;
    end
  end

  // read data taken at setup, stands while ready is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (apb_setup && !pwrite)
      prdata_q <= rd_mux;
  end

  // ************************************************************
  // configuration register
  // ************************************************************
  // partition settings, stored only at the completing access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cfg_q <= `PMG_CFG_RESET;
    else if (wr_hit(`PMG_OFS_CFG))
      cfg_q <= pwdata & `PMG_CFG_MASK;
  end

  // ************************************************************
  // sticky status flags
  // ************************************************************
  // write error: hardware set wins over the software clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      write_error_flag_q <= 1'b0;
    else if (nvm_wr_req && wr_prot)
      write_error_flag_q <= 1'b1;
    else if (wr_hit(`PMG_OFS_NVM_STAT) && pwdata[`PMG_NVM_WRITE_ERROR_FLAG_BIT])
      write_error_flag_q <= 1'b0;
  end

  // violation flag: hardware clear wins over the software set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      viol_flag_q <= `PMG_VIOL_RESET;
    else if (bad_fetch)
      viol_flag_q <= 1'b0;
    else if (wr_hit(`PMG_OFS_PWR_STAT) && pwdata[`PMG_PWR_VIOL_BIT])
      viol_flag_q <= 1'b1;
  end

  // ************************************************************
  // execution violation reset
  // ************************************************************
  // one-cycle reset request on a fetch outside valid execution
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      exec_viol_reset_q <= 1'b0;
    else
      exec_viol_reset_q <= bad_fetch;
  end

  // ************************************************************
  // nonvolatile write gate
  // ************************************************************
  // verdict pulses, exactly one per request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_wr_en_q  <= 1'b0;
      nvm_wr_err_q <= 1'b0;
    end else begin
      nvm_wr_en_q  <= nvm_wr_req & ~wr_prot;
      nvm_wr_err_q <= nvm_wr_req & wr_prot;
    end
  end

  // wrapped write address, held until the next request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      nvm_wr_addr_q <= 16'h0000;
    else if (nvm_wr_req)
      nvm_wr_addr_q <= wrap_addr(nvm_wr_addr);
  end

  // ************************************************************
  // indirect access port
  // ************************************************************
  // data reads finish next cycle, program reads one cycle later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q       <= ST_IDLE;
      ind_busy_q  <= 1'b0;
      ind_done_q  <= 1'b0;
      ind_rdata_q <= 8'h00;
      pm_raddr_q  <= 16'h0000;
      dm_we_q     <= 1'b0;
      dm_waddr_q  <= 16'h0000;
      dm_wdata_q  <= 8'h00;
    end else begin
      ind_done_q <= 1'b0;
      dm_we_q    <= 1'b0;
      case (ist_q)
        ST_IDLE: begin
          if (ind_rd_req && ind_ptr[`PMG_PM_SPACE_BIT]) begin
            pm_raddr_q <= wrap_addr({1'b0, ind_ptr[14:0]});
            ist_q      <= ST_PM;
            ind_busy_q <= 1'b1;
          end else if (ind_rd_req) begin
            ind_rdata_q <= dm_rdata;
            ind_done_q  <= 1'b1;
          end else if (ind_wr_req && !ind_ptr[`PMG_PM_SPACE_BIT]) begin
            dm_we_q    <= 1'b1;
            dm_waddr_q <= ind_ptr;
            dm_wdata_q <= ind_wdata;
          end
        end
        ST_PM: begin
          ind_rdata_q <= pm_rdata[7:0];
          ind_done_q  <= 1'b1;
          ind_busy_q  <= 1'b0;
          ist_q       <= ST_IDLE;
        end
        default: begin
          ist_q      <= ST_IDLE;
          ind_busy_q <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// *** hdl/pmg_map.vh ***
`ifndef PMG_MAP_VH
`define PMG_MAP_VH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define PMG_OFS_CFG          12'h000
`define PMG_OFS_NVM_STAT     12'h004
`define PMG_OFS_PWR_STAT     12'h008
`define PMG_OFS_INFO         12'h00c

// ************************************************************
// configuration register fields
// ************************************************************
`define PMG_CFG_BOOT_EN_N    0
`define PMG_CFG_SAF_EN_N     1
`define PMG_CFG_BSIZE_LSB    2
`define PMG_CFG_BSIZE_MSB    4
`define PMG_CFG_WP_APP       8
`define PMG_CFG_WP_BOOT      9
`define PMG_CFG_WP_CFG       10
`define PMG_CFG_WP_SAF       11
`define PMG_CFG_RESET        32'h0000_0003
`define PMG_CFG_MASK         32'h0000_0f1f

// ************************************************************
// status register fields and reset values
// ************************************************************
`define PMG_NVM_WRITE_ERROR_FLAG_BIT    0
`define PMG_PWR_VIOL_BIT     0
`define PMG_VIOL_RESET       1'b1

// ************************************************************
// address map of the program space
// ************************************************************
`define PMG_START_ADDR       16'h0000
`define PMG_SAF_WORDS_M1     16'h007f
`define PMG_BOOT_UNIT        17'h0_0200
`define PMG_CFG_LO           16'h8007
`define PMG_CFG_HI           16'h800b
`define PMG_DIA_LO           16'h8100
`define PMG_DIA_HI           16'h811f
`define PMG_PM_SPACE_BIT     15

// ************************************************************
// partition codes
// ************************************************************
`define PMG_RGN_APP          3'h0
`define PMG_RGN_BOOT         3'h1
`define PMG_RGN_SAF          3'h2
`define PMG_RGN_CFG          3'h3
`define PMG_RGN_DIA          3'h4
`define PMG_RGN_INFO         3'h5

`endif

// *** hdl/pmg_part_decode.v ***
`include "pmg_map.vh"
`default_nettype none

// ************************************************************
// combinational partition decoder
// ************************************************************
module pmg_part_decode #(
  parameter PM_WORDS = 4096
) (
  input  wire [15:0] addr,
  input  wire        boot_en_n,
  input  wire        saf_en_n,
  input  wire [2:0]  bsize_sel,
  output reg  [2:0]  region
);

  localparam integer LAST_INT  = PM_WORDS - 1;
  localparam [15:0]  LAST_ADDR = LAST_INT[15:0];

  reg [16:0] boot_words;
  reg [15:0] boot_last;
  reg [15:0] saf_base;
  reg [15:0] uaddr;

  // boundaries from latched settings, compared in the same cycle
  always @* begin
    boot_words = `PMG_BOOT_UNIT << bsize_sel;
    if (boot_words > PM_WORDS)
      boot_last = LAST_ADDR;
    else
      boot_last = boot_words[15:0] - 16'h0001;
    saf_base = LAST_ADDR - `PMG_SAF_WORDS_M1;
    uaddr    = addr & LAST_ADDR;
    if (addr[`PMG_PM_SPACE_BIT]) begin
      if (addr >= `PMG_DIA_LO && addr <= `PMG_DIA_HI)
        region = `PMG_RGN_DIA;
      else if (addr >= `PMG_CFG_LO && addr <= `PMG_CFG_HI)
        region = `PMG_RGN_CFG;
      else
        region = `PMG_RGN_INFO;
    end else if (!saf_en_n && uaddr >= saf_base) begin
      region = `PMG_RGN_SAF;
    end else if (!boot_en_n && uaddr >= `PMG_START_ADDR && uaddr <= boot_last) begin
      region = `PMG_RGN_BOOT;
    end else begin
      region = `PMG_RGN_APP;
    end
  end

endmodule

`default_nettype wire

// *** verif/pmg_pm_model.sv ***
`default_nettype none
// ************************************************************
// program flash seen by the guard
// ************************************************************
module pmg_pm_model (
  input  wire logic [15:0] pm_raddr_q,
  output var  logic [13:0] pm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // word pattern tied to its address, so stale data shows
  assign pm_rdata = pm_raddr_q[13:0] ^ 14'h2a5a;
endmodule
`default_nettype wire

// *** verif/pmg_guard_sva.sv ***
`default_nettype none
// ************************************************************
// checker of the partition guard
// ************************************************************
module pmg_guard_chk #(
  parameter int PM_WORDS = 4096
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready_q,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        fetch_valid,
  input wire logic [14:0] fetch_addr,
  input wire logic        exec_viol_reset_q,
  input wire logic        ind_rd_req,
  input wire logic        ind_wr_req,
  input wire logic [15:0] ind_ptr,
  input wire logic [7:0]  dm_rdata,
  input wire logic [13:0] pm_rdata,
  input wire logic [15:0] pm_raddr_q,
  input wire logic [7:0]  ind_rdata_q,
  input wire logic        ind_done_q,
  input wire logic        ind_busy_q,
  input wire logic        dm_we_q,
  input wire logic        nvm_wr_req,
  input wire logic [15:0] nvm_wr_addr,
  input wire logic        nvm_wr_en_q,
  input wire logic [15:0] nvm_wr_addr_q,
  input wire logic        nvm_wr_err_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam logic [15:0] M = PM_WORDS - 1;
  logic [11:0] cfg_q;
  logic [16:0] blast;
  logic [15:0] fw, nw;
  logic        saf_f, rq;
  // shadow of the configuration word, stored at the completing access edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cfg_q <= 12'h003;
    else if (psel && penable && pready_q && pwrite && paddr == 12'h000)
      cfg_q <= pwdata[11:0] & 12'hf1f;
  // wrapped addresses and partition bounds
  assign blast = (17'h00200 << cfg_q[4:2]) - 17'h00001;
  assign fw = {1'b0, fetch_addr} & M;
  assign nw = nvm_wr_addr & M;
  assign saf_f = !cfg_q[1] && fw >= M - 16'h007f;
  assign rq = nvm_wr_req && !nvm_wr_addr[15];
  sequence s_pm_issue;
    ind_busy_q && !ind_done_q && pm_raddr_q == ($past(ind_ptr) & M);
  endsequence
  sequence s_pm_done;
    ind_done_q && ind_rdata_q == $past(pm_rdata[7:0]);
  endsequence
  property p_pm_rd; ind_rd_req && !ind_busy_q && ind_ptr[15] |=> s_pm_issue ##1 s_pm_done;
  endproperty
  property p_dm_rd; ind_rd_req && !ind_busy_q && !ind_ptr[15] |=>
    ind_done_q && ind_rdata_q == $past(dm_rdata); endproperty
  property p_pm_wr; ind_wr_req && !ind_rd_req && !ind_busy_q && ind_ptr[15] |=> !dm_we_q;
  endproperty
  property p_app; rq && cfg_q[1:0] == 2'b11 |=> nvm_wr_err_q == $past(cfg_q[8]); endproperty
  property p_boot; rq && cfg_q[1:0] == 2'b10 |=>
    nvm_wr_err_q == $past(({1'b0, nw} <= blast) ? cfg_q[9] : cfg_q[8]); endproperty
  property p_saf; rq && !cfg_q[1] && nw >= M - 16'h007f |=> nvm_wr_err_q == $past(cfg_q[11]);
  endproperty
  property p_one; nvm_wr_req |=> nvm_wr_en_q != nvm_wr_err_q; endproperty
  property p_dia; nvm_wr_req && nvm_wr_addr inside {[16'h8100:16'h811f]} |=> nvm_wr_err_q;
  endproperty
  property p_wrap; rq |=> nvm_wr_addr_q == $past(nw); endproperty
  property p_fetch; 1'b1 |=> exec_viol_reset_q == $past(fetch_valid && saf_f); endproperty
  a_pm_rd: assert property (p_pm_rd) else $error("program read wrong");
  a_dm_rd: assert property (p_dm_rd) else $error("data read wrong");
  a_pm_wr: assert property (p_pm_wr) else $error("program write passed");
  a_app: assert property (p_app) else $error("application verdict");
  a_boot: assert property (p_boot) else $error("boot verdict");
  a_saf: assert property (p_saf) else $error("storage verdict");
  a_one: assert property (p_one) else $error("write answer not single");
  a_dia: assert property (p_dia) else $error("info area written");
  a_wrap: assert property (p_wrap) else $error("write address not wrapped");
  a_fetch: assert property (p_fetch) else $error("violation reset wrong");
endmodule
bind pmg_guard pmg_guard_chk #(.PM_WORDS(PM_WORDS)) pmg_guard_chk_i (.pclk, .presetn, .psel,
  .penable, .pready_q, .pwrite, .paddr, .pwdata, .fetch_valid, .fetch_addr, .exec_viol_reset_q,
  .ind_rd_req, .ind_wr_req, .ind_ptr, .dm_rdata, .pm_rdata, .pm_raddr_q, .ind_rdata_q,
  .ind_done_q, .ind_busy_q, .dm_we_q, .nvm_wr_req, .nvm_wr_addr, .nvm_wr_en_q,
  .nvm_wr_addr_q, .nvm_wr_err_q);
`default_nettype wire

// *** verif/pmg_guard_test.sv ***
`default_nettype none
module pmg_guard_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        fetch_valid = 1'b0, ind_rd_req = 1'b0, ind_wr_req = 1'b0, nvm_wr_req = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata_q, rd;
  logic [14:0] fetch_addr = 15'h0;
  logic [15:0] ind_ptr = 16'h0, nvm_wr_addr = 16'h0, pm_raddr_q, dm_waddr_q, nvm_wr_addr_q;
  logic [7:0]  ind_wdata = 8'hc3, dm_rdata = 8'h5a, ind_rdata_q, dm_wdata_q;
  logic [13:0] pm_rdata;
  logic        pready_q, pslverr_q, exec_viol_reset_q, ind_done_q, ind_busy_q, dm_we_q;
  logic        nvm_wr_en_q, nvm_wr_err_q, se, we;
  int          err_total = 0, checked = 0, cyc = 0;
  pmg_guard #(.PM_WORDS(4096)) pmg_guard_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q, .fetch_valid, .fetch_addr,
    .exec_viol_reset_q, .ind_rd_req, .ind_wr_req, .ind_ptr, .ind_wdata, .dm_rdata, .pm_rdata,
    .pm_raddr_q, .ind_rdata_q, .ind_done_q, .ind_busy_q, .dm_we_q, .dm_waddr_q, .dm_wdata_q,
    .nvm_wr_req, .nvm_wr_addr, .nvm_wr_en_q, .nvm_wr_addr_q, .nvm_wr_err_q);
  pmg_pm_model pmg_pm_model_i (.pm_raddr_q, .pm_rdata);
  always #2.5 pclk = ~pclk;
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      conclude();
    end
  end
  task automatic conclude();
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_q !== 1'b1);
    rd = prdata_q;
    se = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic nvm(input logic [11:0] c, input logic [15:0] a, input logic e);
    apb(1'b1, 12'h000, {20'h0, c});
    @(posedge pclk);
    nvm_wr_req <= 1'b1;
    nvm_wr_addr <= a;
    @(posedge pclk);
    nvm_wr_req <= 1'b0;
    #1 chk({nvm_wr_en_q, nvm_wr_err_q}, {~e, e}, "write verdict");
  endtask
  task automatic fetch(input logic [14:0] a, input logic e);
    @(posedge pclk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    @(posedge pclk);
    fetch_valid <= 1'b0;
    #1 chk(exec_viol_reset_q, e, "violation pulse");
  endtask
  // indirect access, counts cycles to done
  task automatic ind(input logic r, input logic [15:0] p, output int n);
    @(posedge pclk);
    ind_rd_req <= r;
    ind_wr_req <= ~r;
    ind_ptr <= p;
    @(posedge pclk);
    ind_rd_req <= 1'b0;
    ind_wr_req <= 1'b0;
    n = 1;
    #1 we = dm_we_q;
    while (ind_done_q !== 1'b1 && n < 5) begin
      @(posedge pclk);
      #1 n++;
    end
  endtask
  task automatic t_apb();
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h3, "config reset");
    apb(1'b1, 12'h000, 32'hffffffff);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'hf1f, "config mask");
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'hfff, "last address");
    chk(se, 1'b0, "mapped read error");
    apb(1'b0, 12'h010, 32'h0);
    chk(se, 1'b1, "unmapped error");
  endtask
  task automatic t_fetch();
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[0], 1'b1, "violation flag reset");
    apb(1'b1, 12'h000, 32'h001);
    fetch(15'h0f7f, 1'b0);
    fetch(15'h0f80, 1'b1);
    fetch(15'h1fff, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[0], 1'b0, "violation flag cleared");
  endtask
  task automatic t_nvm();
    nvm(12'h003, 16'h0123, 1'b0);
    nvm(12'h103, 16'h0ffe, 1'b1);
    nvm(12'h101, 16'h0f80, 1'b0);
    nvm(12'h101, 16'h0f7f, 1'b1);
    nvm(12'h801, 16'h0f80, 1'b1);
    nvm(12'h202, 16'h01ff, 1'b1);
    nvm(12'h202, 16'h0200, 1'b0);
    nvm(12'h206, 16'h03ff, 1'b1);
    nvm(12'h003, 16'h8105, 1'b1);
    nvm(12'h003, 16'h8007, 1'b0);
    nvm(12'h403, 16'h800b, 1'b1);
    nvm(12'h801, 16'h1f80, 1'b1);
    chk(nvm_wr_addr_q, 32'h0f80, "wrapped address");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[0], 1'b1, "error flag");
  endtask
  // software clear and set of the flags, then a reset in mid-run
  task automatic t_flags();
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[0], 1'b0, "error flag cleared");
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[0], 1'b1, "violation flag set");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h3, "config after reset");
  endtask
  task automatic t_ind();
    int nd, np;
    ind(1'b1, 16'h0020, nd);
    chk(ind_rdata_q, 32'h5a, "data read");
    ind(1'b1, 16'h8003, np);
    chk(ind_rdata_q, 32'h59, "program read byte");
    chk(np, nd + 1, "extra read cycle");
    ind(1'b0, 16'h8010, nd);
    chk(we, 1'b0, "program write dropped");
    ind(1'b0, 16'h0021, nd);
    chk(we, 1'b1, "data write passes");
    chk(dm_waddr_q, 32'h0021, "data write address");
    chk(dm_wdata_q, 32'hc3, "data write value");
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_apb();
    t_fetch();
    t_nvm();
    t_flags();
    t_ind();
    conclude();
  end
endmodule
`default_nettype wire
